// [dcb_defines.svh]
// Constants of the data compare block: widths, codes, reset values
`ifndef DCB_DEFINES_SVH
`define DCB_DEFINES_SVH

// Operand and code widths
`define DCB_DATA_W       32
`define DCB_HALF_W       16
`define DCB_EXT_W        33
`define DCB_VT_W         2
`define DCB_REL_W        3

// Value type codes
`define DCB_VT_WORD      2'h0
`define DCB_VT_INT       2'h1
`define DCB_VT_DWORD     2'h2
`define DCB_VT_LONG      2'h3
`define DCB_VT_RESET     2'h1

// Relation codes
`define DCB_REL_EQ       3'h0
`define DCB_REL_NE       3'h1
`define DCB_REL_LT       3'h2
`define DCB_REL_GT       3'h3
`define DCB_REL_LE       3'h4
`define DCB_REL_GE       3'h5

// Reset and substitute values
`define DCB_OUT_RESET    1'b0
`define DCB_ZERO_OPERAND 32'h0000_0000
`define DCB_HALF_ZERO    16'h0000

`endif

// [dcb_pkg.sv]
// Types of the data compare block
`include "dcb_defines.svh"

package dcb_pkg;

    // Interpretation of both operands
    typedef enum logic [`DCB_VT_W-1:0] {
        DCB_VT_WORD  = `DCB_VT_WORD,
        DCB_VT_INT   = `DCB_VT_INT,
        DCB_VT_DWORD = `DCB_VT_DWORD,
        DCB_VT_LONG  = `DCB_VT_LONG
    } dcb_vtype_t;

    // Relation between operand one and operand two
    typedef enum logic [`DCB_REL_W-1:0] {
        DCB_REL_EQ = `DCB_REL_EQ,
        DCB_REL_NE = `DCB_REL_NE,
        DCB_REL_LT = `DCB_REL_LT,
        DCB_REL_GT = `DCB_REL_GT,
        DCB_REL_LE = `DCB_REL_LE,
        DCB_REL_GE = `DCB_REL_GE
    } dcb_rel_t;

endpackage : dcb_pkg

// [dcb_cmp_if.sv]
// Carrier between the compare top and its relation evaluator
`include "dcb_defines.svh"

interface dcb_cmp_if;

    logic [`DCB_DATA_W-1:0] opa;
    logic [`DCB_DATA_W-1:0] opb;
    dcb_pkg::dcb_vtype_t    vtype;
    dcb_pkg::dcb_rel_t      rel;
    logic                   holds;
    logic                   rel_known;
    logic                   range_ok;

    // Evaluator side
    modport eval (
        input  opa,
        input  opb,
        input  vtype,
        input  rel,
        output holds,
        output rel_known,
        output range_ok
    );

    // Control side
    modport ctrl (
        output opa,
        output opb,
        output vtype,
        output rel,
        input  holds,
        input  rel_known,
        input  range_ok
    );

endinterface : dcb_cmp_if

// [dcb_relation_eval.sv]
// Combinational relation evaluator for the data compare block
`include "dcb_defines.svh"

module dcb_relation_eval (
    dcb_cmp_if.eval bus
);

    // Widen a raw operand to a common signed form per value type
    function automatic logic signed [`DCB_EXT_W-1:0] dcb_extend(
        input logic [`DCB_DATA_W-1:0] v,
        input dcb_pkg::dcb_vtype_t    t
    );
        logic [`DCB_EXT_W-1:0] r;
        case (t)
            dcb_pkg::DCB_VT_WORD:
                r = {{(`DCB_EXT_W-`DCB_HALF_W){1'b0}},
                     v[`DCB_HALF_W-1:0]};
            dcb_pkg::DCB_VT_INT:
                r = {{(`DCB_EXT_W-`DCB_HALF_W){v[`DCB_HALF_W-1]}},
                     v[`DCB_HALF_W-1:0]};
            dcb_pkg::DCB_VT_DWORD:
                r = {1'b0, v};
            default:
                r = {v[`DCB_DATA_W-1], v};
        endcase
        return $signed(r);
    endfunction : dcb_extend

    // Upper half must be a pure extension for 16-bit types
    function automatic logic dcb_in_range(
        input logic [`DCB_DATA_W-1:0] v,
        input dcb_pkg::dcb_vtype_t    t
    );
        logic ok;
        case (t)
            dcb_pkg::DCB_VT_WORD:
                ok = (v[`DCB_DATA_W-1:`DCB_HALF_W] == `DCB_HALF_ZERO);
            dcb_pkg::DCB_VT_INT:
                ok = (v[`DCB_DATA_W-1:`DCB_HALF_W]
                      == {`DCB_HALF_W{v[`DCB_HALF_W-1]}});
            default:
                ok = 1'b1;
        endcase
        return ok;
    endfunction : dcb_in_range

    logic signed [`DCB_EXT_W-1:0] ext_a;
    logic signed [`DCB_EXT_W-1:0] ext_b;

    // One type governs both operands, so width and sign always agree
    always_comb
    begin
        ext_a         = dcb_extend(bus.opa, bus.vtype);
        ext_b         = dcb_extend(bus.opb, bus.vtype);
        bus.rel_known = 1'b1;
        case (bus.rel)
            dcb_pkg::DCB_REL_EQ: bus.holds = (ext_a == ext_b);
            dcb_pkg::DCB_REL_NE: bus.holds = (ext_a != ext_b);
            dcb_pkg::DCB_REL_LT: bus.holds = (ext_a < ext_b);
            dcb_pkg::DCB_REL_GT: bus.holds = (ext_a > ext_b);
            dcb_pkg::DCB_REL_LE: bus.holds = (ext_a <= ext_b);
            dcb_pkg::DCB_REL_GE: bus.holds = (ext_a >= ext_b);
            default:
            begin
                bus.holds     = 1'b0;
                bus.rel_known = 1'b0;
            end
        endcase
        bus.range_ok = dcb_in_range(bus.opa, bus.vtype)
                       && dcb_in_range(bus.opb, bus.vtype);
    end

endmodule : dcb_relation_eval

// [dcb_compare.sv]
// Top of the data compare block: settings, result register, checks
`include "dcb_defines.svh"

module dcb_compare (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    input  wire logic                   exec_en,
    input  wire logic [`DCB_DATA_W-1:0] operand_one,
    input  wire logic                   operand_one_valid,
    input  wire logic [`DCB_DATA_W-1:0] operand_two,
    input  wire logic                   operand_two_valid,
    input  wire logic [`DCB_VT_W-1:0]   value_type_select,
    input  wire logic                   type_load,
    input  wire logic [`DCB_REL_W-1:0]  relation_select,
    output logic                        cmp_out,
    output logic                        range_error,
    output logic                        relation_invalid,
    output logic [`DCB_VT_W-1:0]        active_type
);

    dcb_cmp_if cmp_bus ();

    logic next_cmp_out;
    logic next_range_error;
    logic next_relation_invalid;

    // Unconnected operands become zero before evaluation
    assign cmp_bus.opa = operand_one_valid ? operand_one
                                           : `DCB_ZERO_OPERAND;
    assign cmp_bus.opb = operand_two_valid ? operand_two
                                           : `DCB_ZERO_OPERAND;

    // Stored type and live relation feed the evaluator
    assign cmp_bus.vtype = dcb_pkg::dcb_vtype_t'(active_type);
    assign cmp_bus.rel   = dcb_pkg::dcb_rel_t'(relation_select);

    dcb_relation_eval u_eval (
        .bus (cmp_bus.eval)
    );

    // Result and status for the coming edge
    always_comb
    begin
        next_cmp_out = exec_en && cmp_bus.rel_known
                       && cmp_bus.holds;
        next_range_error      = exec_en && !cmp_bus.range_ok;
        next_relation_invalid = exec_en && !cmp_bus.rel_known;
    end

    // Type setting: signed 16-bit until software loads another
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            active_type <= `DCB_VT_RESET;
        else if (clk_en && type_load)
            active_type <= value_type_select;
    end

    // Registered comparison result
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cmp_out <= `DCB_OUT_RESET;
        else if (clk_en)
            cmp_out <= next_cmp_out;
    end

    // Status flags: operand out of range, unknown relation code
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            range_error      <= 1'b0;
            relation_invalid <= 1'b0;
        end
        else if (clk_en)
        begin
            range_error      <= next_range_error;
            relation_invalid <= next_relation_invalid;
        end
    end

    // Checks

    // Reference values built apart from the evaluator
    logic signed [`DCB_EXT_W-1:0] ref_a;
    logic signed [`DCB_EXT_W-1:0] ref_b;

    // Independent widening of both operands under the stored type
    always_comb
    begin
        ref_a = $signed({1'b0, cmp_bus.opa});
        ref_b = $signed({1'b0, cmp_bus.opb});
        case (active_type)
            `DCB_VT_WORD:
            begin
                ref_a = $signed({{(`DCB_EXT_W-`DCB_HALF_W){1'b0}},
                                 cmp_bus.opa[`DCB_HALF_W-1:0]});
                ref_b = $signed({{(`DCB_EXT_W-`DCB_HALF_W){1'b0}},
                                 cmp_bus.opb[`DCB_HALF_W-1:0]});
            end
            `DCB_VT_INT:
            begin
                ref_a = $signed({{(`DCB_EXT_W-`DCB_HALF_W)
                                  {cmp_bus.opa[`DCB_HALF_W-1]}},
                                 cmp_bus.opa[`DCB_HALF_W-1:0]});
                ref_b = $signed({{(`DCB_EXT_W-`DCB_HALF_W)
                                  {cmp_bus.opb[`DCB_HALF_W-1]}},
                                 cmp_bus.opb[`DCB_HALF_W-1:0]});
            end
            `DCB_VT_LONG:
            begin
                ref_a = $signed({cmp_bus.opa[`DCB_DATA_W-1],
                                 cmp_bus.opa});
                ref_b = $signed({cmp_bus.opb[`DCB_DATA_W-1],
                                 cmp_bus.opb});
            end
            default:
            begin
                ref_a = $signed({1'b0, cmp_bus.opa});
                ref_b = $signed({1'b0, cmp_bus.opb});
            end
        endcase
    end

    // Sampling condition for an enabled evaluation of a given relation
    logic live;
    assign live = clk_en && exec_en;

    default clocking dcb_cb @(posedge sys_clk);
    endclocking

    default disable iff (rst);

    // Disabled: low on the next edge, whatever the inputs
    chk_disable_forces_low:
    assert property (clk_en && !exec_en |=> !cmp_out)
    else $error("output not low while execution input off");

    // Enabled with a known relation: output follows the reference
    chk_enabled_tracks_rel:
    assert property (live && relation_select == `DCB_REL_NE
                     |=> cmp_out == ($past(ref_a) != $past(ref_b)))
    else $error("not-equal result differs from reference");

    chk_rel_equal_match:
    assert property (live && relation_select == `DCB_REL_EQ
                     |=> cmp_out == ($past(ref_a) == $past(ref_b)))
    else $error("equal result differs from reference");

    chk_rel_less_strict:
    assert property (live && relation_select == `DCB_REL_LT
                     |=> cmp_out == ($past(ref_a) < $past(ref_b)))
    else $error("less-than result differs from reference");

    chk_rel_greater_strict:
    assert property (live && relation_select == `DCB_REL_GT
                     |=> cmp_out == ($past(ref_a) > $past(ref_b)))
    else $error("greater-than result differs from reference");

    chk_rel_less_equal:
    assert property (live && relation_select == `DCB_REL_LE
                     |=> cmp_out == !($past(ref_a) > $past(ref_b)))
    else $error("less-or-equal result differs from reference");

    chk_rel_greater_equal:
    assert property (live && relation_select == `DCB_REL_GE
                     |=> cmp_out == !($past(ref_a) < $past(ref_b)))
    else $error("greater-or-equal result differs from reference");

    // Word type: low half with its top bit set is large, never below zero
    chk_word_unsigned_cmp:
    assert property (live && active_type == `DCB_VT_WORD
                     && relation_select == `DCB_REL_LT
                     && cmp_bus.opa[`DCB_HALF_W-1]
                     && cmp_bus.opb[`DCB_HALF_W-1:0] == `DCB_HALF_ZERO
                     |=> !cmp_out)
    else $error("word type compared as signed");

    // Integer type: negative low half is below any positive one
    chk_int_signed_cmp:
    assert property (live && active_type == `DCB_VT_INT
                     && relation_select == `DCB_REL_LT
                     && cmp_bus.opa[`DCB_HALF_W-1]
                     && !cmp_bus.opb[`DCB_HALF_W-1]
                     |=> cmp_out)
    else $error("integer type compared as unsigned");

    // Long type: sign bit set means smaller than a clear one
    chk_long_signed_cmp:
    assert property (live && active_type == `DCB_VT_LONG
                     && relation_select == `DCB_REL_GT
                     && cmp_bus.opa[`DCB_DATA_W-1]
                     && !cmp_bus.opb[`DCB_DATA_W-1]
                     |=> !cmp_out)
    else $error("long type compared as unsigned");

    // First edge after reset release still holds the signed 16-bit type
    chk_type_reset_default:
    assert property ($past(rst) |-> active_type == `DCB_VT_INT)
    else $error("type not integer after reset");

    // Type changes only through a load or a reset
    chk_type_load_only:
    assert property (!$past(rst) && !$past(clk_en && type_load)
                     |-> $stable(active_type))
    else $error("type changed without a load");

    // Two unconnected operands are equal zeros
    chk_zero_unconnected:
    assert property (live && !operand_one_valid && !operand_two_valid
                     && relation_select == `DCB_REL_EQ
                     ##1 1'b1 |-> cmp_out)
    else $error("unconnected operands not treated as zero");

    // Unconnected operand one below a connected positive operand two
    chk_zero_one_side:
    assert property (live && !operand_one_valid && operand_two_valid
                     && relation_select == `DCB_REL_GE
                     && active_type == `DCB_VT_DWORD
                     && cmp_bus.opb != `DCB_ZERO_OPERAND
                     |=> !cmp_out)
    else $error("unconnected operand one not zero");

    // Synchronous reset clears the output at the next edge
    chk_reset_clears_out:
    assert property (@(posedge sys_clk) disable iff (1'b0)
                     rst |=> !cmp_out && !range_error
                     && !relation_invalid)
    else $error("reset did not clear outputs");

    // Frozen clock enable keeps every output steady
    chk_freeze_holds:
    assert property (!clk_en |=> $stable(cmp_out)
                     && $stable(range_error)
                     && $stable(relation_invalid)
                     && $stable(active_type))
    else $error("state moved while clock enable low");

    // Out-of-range operand is reported one edge later
    chk_range_flag:
    assert property (live && !cmp_bus.range_ok |=> range_error)
    else $error("out-of-range operand not flagged");

    // In-range operands leave the range flag clear
    chk_range_flag_clear:
    assert property (live && cmp_bus.range_ok |=> !range_error)
    else $error("range flag raised for in-range operands");

    // Codes beyond the six relations force the output low
    chk_bad_code_low:
    assert property (live && relation_select > `DCB_REL_GE
                     |=> !cmp_out && relation_invalid)
    else $error("unknown relation code not refused");

    // Disabled: both status flags low on the next edge
    chk_flags_low_disabled:
    assert property (clk_en && !exec_en
                     |=> !range_error && !relation_invalid)
    else $error("status flags not low while execution input off");

    // A load takes the code present at its edge
    chk_type_load_value:
    assert property (clk_en && type_load
                     |=> active_type == $past(value_type_select))
    else $error("loaded type differs from the selected code");

    // Double-word type: top bit set is large, never negative
    chk_dword_unsigned_cmp:
    assert property (live && active_type == `DCB_VT_DWORD
                     && relation_select == `DCB_REL_GT
                     && cmp_bus.opa[`DCB_DATA_W-1]
                     && !cmp_bus.opb[`DCB_DATA_W-1]
                     |=> cmp_out)
    else $error("double-word type compared as signed");

    // Main scenarios
    cov_true_then_false:
    cover property (live && next_cmp_out ##1 live && !next_cmp_out
                    ##1 !cmp_out);

    cov_disable_while_true:
    cover property (cmp_out ##1 clk_en && !exec_en ##1 !cmp_out);

    cov_type_switch_long:
    cover property (clk_en && type_load
                    && value_type_select == `DCB_VT_LONG
                    ##1 live ##1 cmp_out);

    cov_bad_relation:
    cover property (relation_invalid);

    cov_unconnected_equal:
    cover property (live && !operand_one_valid && !operand_two_valid
                    ##1 cmp_out);

endmodule : dcb_compare

// [dcb_src_model.sv]
// Operand source model standing in for the surrounding control logic
module dcb_src_model (
    input  wire logic        sys_clk,
    input  wire logic [31:0] one_val,
    input  wire logic        one_on,
    input  wire logic [31:0] two_val,
    input  wire logic        two_on,
    output logic      [31:0] operand_one,
    output logic             operand_one_valid,
    output logic      [31:0] operand_two,
    output logic             operand_two_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] noise = 32'h0F0F_0F0F;

    // Floating source shows a pattern that changes every cycle
    always @(negedge sys_clk)
    begin
        noise <= {noise[30:0], ~noise[31]} ^ 32'hA5C3_5A3C;
    end

    // Connected source passes the value chosen by the bench, in range or not
    always_comb
    begin
        operand_one       = one_on ? one_val : noise;
        operand_one_valid = one_on;
        operand_two       = two_on ? two_val : noise;
        operand_two_valid = two_on;
    end
endmodule : dcb_src_model

// [dcb_compare_tb_top.sv]
// Self-checking testbench of the data compare block
module dcb_compare_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk, rst, clk_en, exec_en, type_load;
    logic [31:0] one_val, two_val, operand_one, operand_two;
    logic        one_on, two_on, operand_one_valid, operand_two_valid;
    logic [1:0]  value_type_select, active_type, cur_t;
    logic [2:0]  relation_select;
    logic        cmp_out, range_error, relation_invalid;
    int          n_mismatch, checks, cycles;

    dcb_src_model u_src (
        .sys_clk(sys_clk), .one_val(one_val), .one_on(one_on),
        .two_val(two_val), .two_on(two_on), .operand_one(operand_one),
        .operand_one_valid(operand_one_valid),
        .operand_two(operand_two),
        .operand_two_valid(operand_two_valid)
    );

    dcb_compare u_dut (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .exec_en(exec_en), .operand_one(operand_one),
        .operand_one_valid(operand_one_valid),
        .operand_two(operand_two),
        .operand_two_valid(operand_two_valid),
        .value_type_select(value_type_select), .type_load(type_load),
        .relation_select(relation_select), .cmp_out(cmp_out),
        .range_error(range_error), .relation_invalid(relation_invalid),
        .active_type(active_type)
    );

    // Clock generation
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            results();
        end
    end

    // Expected result from operands, type and relation code
    function automatic logic expv(input logic en, input logic [31:0] a,
        input logic [31:0] b, input logic [1:0] t, input logic [2:0] r);
        logic signed [32:0] x;
        logic signed [32:0] y;
        x = t[1] ? {t[0] & a[31], a} : {{17{t[0] & a[15]}}, a[15:0]};
        y = t[1] ? {t[0] & b[31], b} : {{17{t[0] & b[15]}}, b[15:0]};
        case (r)
            3'h0: return en && x == y;
            3'h1: return en && x != y;
            3'h2: return en && x < y;
            3'h3: return en && x > y;
            3'h4: return en && x <= y;
            3'h5: return en && x >= y;
            default: return 1'b0;
        endcase
    endfunction : expv

    // Both operands inside the range of the type
    function automatic logic inr(input logic [31:0] a, input logic [31:0] b,
                                 input logic [1:0] t);
        return t[1] || (a[31:16] == {16{t[0] & a[15]}}
                        && b[31:16] == {16{t[0] & b[15]}});
    endfunction : inr

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    // One compare: drive at a falling edge, judge at the next one
    task automatic cmp(input logic en, input logic [31:0] a,
                       input logic [31:0] b, input logic [2:0] r);
        exec_en = en;
        one_val = a;
        two_val = b;
        relation_select = r;
        @(negedge sys_clk);
        chk("cmp_out", expv(en, a, b, cur_t, r), cmp_out);
        chk("relation_invalid", en && r > 3'h5, relation_invalid);
        chk("range_error", en && !inr(a, b, cur_t), range_error);
    endtask : cmp

    task automatic load(input logic [1:0] t);
        type_load = 1'b1;
        value_type_select = t;
        @(negedge sys_clk);
        type_load = 1'b0;
        cur_t = t;
        chk("active_type", t, active_type);
    endtask : load

    // Type loaded at the same edge as a compare applies only afterwards
    task automatic t_order;
        type_load = 1'b1;
        value_type_select = dcb_pkg::DCB_VT_WORD;
        cmp(1'b1, 32'h0000_8000, 32'h0000_0001, 3'h2);
        type_load = 1'b0;
        cur_t = 2'h0;
        cmp(1'b1, 32'h0000_8000, 32'h0000_0001, 3'h2);
        cmp(1'b1, 32'h0000_8000, 32'h0000_0000, 3'h2);
    endtask : t_order

    // Every relation in every type, below, equal and above
    task automatic t_rel;
        logic [31:0] hi [4];
        hi = '{32'h0000_FFFF, 32'hFFFF_8000, 32'hFFFF_FFFF, 32'h8000_0000};
        for (int t = 0; t < 4; t++)
        begin
            load(2'(t));
            for (int r = 0; r < 6; r++)
            begin
                cmp(1'b1, 32'h0000_0001, hi[t], 3'(r));
                cmp(1'b1, hi[t], hi[t], 3'(r));
                cmp(1'b1, hi[t], 32'h0000_0001, 3'(r));
            end
        end
    endtask : t_rel

    task automatic t_disable;
        cmp(1'b0, 32'h0000_0009, 32'h0000_0009, 3'h0);
        cmp(1'b0, 32'h0000_0001, 32'h0000_0002, 3'h2);
        cmp(1'b0, 32'h0000_0000, 32'h0000_0000, 3'h6);
    endtask : t_disable

    task automatic t_invalid;
        cmp(1'b1, 32'h0000_0004, 32'h0000_0004, 3'h6);
        cmp(1'b1, 32'h0000_0004, 32'h0000_0004, 3'h7);
    endtask : t_invalid

    // Unconnected operands count as zero despite noise on the lines
    task automatic t_float;
        load(2'h2);
        one_on = 1'b0;
        cmp(1'b1, 32'h0000_0000, 32'h0000_0000, 3'h0);
        cmp(1'b1, 32'h0000_0000, 32'h0000_0005, 3'h5);
        two_on = 1'b0;
        cmp(1'b1, 32'h0000_0000, 32'h0000_0000, 3'h1);
        cmp(1'b1, 32'h0000_0000, 32'h0000_0000, 3'h0);
        one_on = 1'b1;
        cmp(1'b1, 32'h0000_0003, 32'h0000_0000, 3'h3);
        two_on = 1'b1;
    endtask : t_float

    // Clock enable low freezes result and type
    task automatic t_freeze;
        cmp(1'b1, 32'h0000_0005, 32'h0000_0007, 3'h2);
        clk_en = 1'b0;
        exec_en = 1'b0;
        type_load = 1'b1;
        value_type_select = 2'h3;
        repeat (2) @(negedge sys_clk);
        chk("cmp_out", 1'b1, cmp_out);
        chk("active_type", cur_t, active_type);
        clk_en = 1'b1;
        type_load = 1'b0;
    endtask : t_freeze

    // Reset in mid-run clears output and restores signed 16-bit type
    task automatic t_midreset;
        cmp(1'b1, 32'h0000_0005, 32'h0000_0005, 3'h0);
        rst = 1'b1;
        @(negedge sys_clk);
        chk("cmp_out", 1'b0, cmp_out);
        chk("active_type", 2'h1, active_type);
        rst = 1'b0;
        cur_t = 2'h1;
        cmp(1'b1, 32'hFFFF_FFFF, 32'h0000_0001, 3'h2);
    endtask : t_midreset

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    // Main sequence
    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        exec_en = 1'b0;
        type_load = 1'b0;
        value_type_select = 2'h1;
        relation_select = 3'h0;
        one_val = 32'h0000_0000;
        two_val = 32'h0000_0000;
        one_on = 1'b1;
        two_on = 1'b1;
        cur_t = 2'h1;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        chk("cmp_out", 1'b0, cmp_out);
        chk("active_type", 2'h1, active_type);
        t_order();
        t_rel();
        t_disable();
        t_invalid();
        t_float();
        t_freeze();
        t_midreset();
        results();
    end
endmodule : dcb_compare_tb_top
